// file: ssrm_top.sv
// Serial register map: shift register, latch strobe, double buffering
`timescale 1ns/100ps
// Summary of operation
// - A word whose low three select bits are 000 goes to the frequency word register on the strobe.
// - The frequency word register carries a 16-bit integer divide word at bits 30 to 15.
// - The frequency word register carries a 12-bit fraction numerator at bits 14 to 3.
// - Buffered fields keep their working value until the next frequency word write.
// - Output divider select is held until a frequency word write only while bit 13 of register 2 is set.
// - Serial data shifts into a 32-bit register, MSB first, on each rising serial clock edge.
// - The first serial clock rise with strobe high copies the shift register to the latch named by the low three bits, 001..101.
// - Band selection starts at power-up and on every frequency word register update.
module ssrm_top
  import ssrm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        sclk,
  input  wire logic        sdata,
  input  wire logic        latch_strobe,
  output ssrm_freq_t       freq_ff,
  output ssrm_held_t       held_ff,
  output logic [2:0]       out_div_ff,
  output logic [WORD_W-1:0] mod_reg_ff,
  output logic [WORD_W-1:0] ref_reg_ff,
  output logic [WORD_W-1:0] clk_reg_ff,
  output logic [WORD_W-1:0] out_reg_ff,
  output logic [WORD_W-1:0] lock_reg_ff,
  output logic             band_start_ff
);
  // Link domain: shift register on the serial clock
  logic [WORD_W-1:0] shift_ff;
  logic [WORD_W-1:0] hold_word_ff;
  logic              le_s1_ff;
  // Power-up value only; no reset reaches the link side
  logic              tog_ff = 1'b0;

  always_ff @(posedge sclk) begin
    shift_ff <= {shift_ff[WORD_W-2:0], sdata};
  end

  // First serial clock rise with strobe high takes the word as it stood
  // before that rise shifts again; later rises only shift.
  // Host must give a serial clock edge while strobe is high.
  always_ff @(posedge sclk) begin
    le_s1_ff <= latch_strobe;
  end

  always_ff @(posedge sclk) begin
    if (latch_strobe && !le_s1_ff) begin
      hold_word_ff <= shift_ff;
      tog_ff       <= ~tog_ff;
    end
  end

  // System domain: toggle synchroniser, word stable while toggle settles
  logic [SYNC_STAGES-1:0] tog_sync_ff;
  logic                   tog_seen_ff;
  logic                   wr_pulse;
  logic [WORD_W-1:0]      wr_word;

  always_ff @(posedge clk) begin
    if (rst) begin
      tog_sync_ff <= '0;
      tog_seen_ff <= 1'b0;
    end else begin
      tog_sync_ff <= {tog_sync_ff[SYNC_STAGES-2:0], tog_ff};
      tog_seen_ff <= tog_sync_ff[SYNC_STAGES-1];
    end
  end

  assign wr_pulse = tog_sync_ff[SYNC_STAGES-1] ^ tog_seen_ff;
  assign wr_word  = hold_word_ff;

  logic [NUM_REGS*WORD_W-1:0] regs_flat;

  ssrm_latch_bank #(
    .N_REGS (NUM_REGS)
  ) u_bank (
    .clk       (clk),
    .rst       (rst),
    .wr_en     (wr_pulse),
    .wr_sel    (wr_word[SEL_W-1:0]),
    .wr_data   (wr_word),
    .regs_flat (regs_flat)
  );

  logic freq_wr;
  assign freq_wr = wr_pulse && (wr_word[SEL_W-1:0] == SEL_FREQ);

  function automatic logic [WORD_W-1:0] reg_of(input logic [NUM_REGS*WORD_W-1:0] f, input int idx);
    reg_of = f[idx*WORD_W +: WORD_W];
  endfunction

  logic [WORD_W-1:0] r1;
  logic [WORD_W-1:0] r2;
  logic [WORD_W-1:0] r4;
  assign r1 = reg_of(regs_flat, 1);
  assign r2 = reg_of(regs_flat, 2);
  assign r4 = reg_of(regs_flat, 4);

  // Working frequency word
  always_ff @(posedge clk) begin
    if (rst) begin
      freq_ff <= '0;
    end else if (freq_wr) begin
      freq_ff.int_word           <= wr_word[INT_MSB:INT_LSB];
      freq_ff.fraction_numerator <= wr_word[FRACTION_NUMERATOR_MSB:FRACTION_NUMERATOR_LSB];
    end
  end

  // Buffered fields commit with the frequency word; latched on the same edge as
  // the bank write, from r1 and r2 as they stood before that edge.
  always_ff @(posedge clk) begin
    if (rst) begin
      held_ff <= '0;
    end else if (freq_wr) begin
      held_ff.phase_word       <= r1[PHASE_MSB:PHASE_LSB];
      held_ff.fraction_modulus <= r1[MODUL_MSB:MODUL_LSB];
      held_ff.ref_doubler      <= r2[DOUBLER_BIT];
      held_ff.ref_halve        <= r2[HALVE_BIT];
      held_ff.ref_count        <= r2[RCNT_MSB:RCNT_LSB];
      held_ff.pump_current     <= r2[PUMP_MSB:PUMP_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      out_div_ff <= '0;
    end else if (!r2[HOLD_EN_BIT] || freq_wr) begin
      out_div_ff <= r4[ODIV_MSB:ODIV_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mod_reg_ff  <= REG_RESET;
      ref_reg_ff  <= REG_RESET;
      clk_reg_ff  <= REG_RESET;
      out_reg_ff  <= REG_RESET;
      lock_reg_ff <= REG_RESET;
    end else begin
      mod_reg_ff  <= r1;
      ref_reg_ff  <= r2;
      clk_reg_ff  <= reg_of(regs_flat, 3);
      out_reg_ff  <= r4;
      lock_reg_ff <= reg_of(regs_flat, 5);
    end
  end

  // Band start pulses after reset (power-up) and on each frequency word write
  logic boot_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      boot_ff       <= 1'b1;
      band_start_ff <= 1'b0;
    end else begin
      boot_ff       <= 1'b0;
      band_start_ff <= boot_ff || freq_wr;
    end
  end

  freq_load_a: assert property (@(posedge clk) disable iff (rst)
    freq_wr |=> freq_ff.int_word == $past(wr_word[INT_MSB:INT_LSB]))
    else $error("integer word not loaded");
  fraction_numerator_load_a: assert property (@(posedge clk) disable iff (rst)
    freq_wr |=> freq_ff.fraction_numerator == $past(wr_word[FRACTION_NUMERATOR_MSB:FRACTION_NUMERATOR_LSB]))
    else $error("fraction not loaded");
  freq_hold_a: assert property (@(posedge clk) disable iff (rst)
    !freq_wr |=> $stable(freq_ff))
    else $error("frequency word changed without select 000");
  held_keep_a: assert property (@(posedge clk) disable iff (rst)
    !freq_wr |=> $stable(held_ff))
    else $error("buffered field changed early");
  held_mod_a: assert property (@(posedge clk) disable iff (rst)
    freq_wr |=> held_ff.fraction_modulus == $past(r1[MODUL_MSB:MODUL_LSB]))
    else $error("modulus not committed");
  div_hold_a: assert property (@(posedge clk) disable iff (rst)
    r2[HOLD_EN_BIT] && !freq_wr |=> $stable(out_div_ff))
    else $error("divider select leaked while held");
  div_direct_a: assert property (@(posedge clk) disable iff (rst)
    !r2[HOLD_EN_BIT] |=> out_div_ff == $past(r4[ODIV_MSB:ODIV_LSB]))
    else $error("divider select not immediate");
  band_start_a: assert property (@(posedge clk) disable iff (rst)
    freq_wr |=> band_start_ff)
    else $error("band selection not started");
  shift_in_a: assert property (@(posedge sclk)
    1'b1 |=> shift_ff[0] == $past(sdata))
    else $error("serial bit not shifted in");
  cap_word_a: assert property (@(posedge sclk)
    latch_strobe && !le_s1_ff |=> hold_word_ff == $past(shift_ff))
    else $error("word not captured on strobe edge");
  bank_write_a: assert property (@(posedge clk) disable iff (rst)
    wr_pulse && wr_word[SEL_W-1:0] == SEL_MOD |=> r1 == $past(wr_word))
    else $error("register 1 not written");
  bank_div_a: assert property (@(posedge clk) disable iff (rst)
    wr_pulse && wr_word[SEL_W-1:0] == SEL_OUT |=> r4 == $past(wr_word))
    else $error("register 4 not written");
  bad_sel_a: assert property (@(posedge clk) disable iff (rst)
    wr_pulse && wr_word[SEL_W-1:0] > SEL_LOCK |=> $stable(regs_flat))
    else $error("unused select code wrote a register");
  wr_single_a: assert property (@(posedge clk) disable iff (rst)
    wr_pulse |=> !wr_pulse)
    else $error("one strobe gave two writes");
  band_once_a: assert property (@(posedge clk) disable iff (rst)
    band_start_ff |=> !band_start_ff)
    else $error("band start longer than one cycle");
  held_phase_a: assert property (@(posedge clk) disable iff (rst)
    freq_wr |=> held_ff.phase_word == $past(r1[PHASE_MSB:PHASE_LSB]))
    else $error("phase word not committed");
  held_ref_a: assert property (@(posedge clk) disable iff (rst)
    freq_wr |=> held_ff.ref_count == $past(r2[RCNT_MSB:RCNT_LSB]))
    else $error("reference count not committed");
  held_pump_a: assert property (@(posedge clk) disable iff (rst)
    freq_wr |=> held_ff.pump_current == $past(r2[PUMP_MSB:PUMP_LSB]))
    else $error("pump current not committed");
  held_dbl_a: assert property (@(posedge clk) disable iff (rst)
    freq_wr |=> {held_ff.ref_doubler, held_ff.ref_halve} == $past(r2[DOUBLER_BIT:HALVE_BIT]))
    else $error("reference doubler or halving not committed");
  div_commit_a: assert property (@(posedge clk) disable iff (rst)
    freq_wr |=> out_div_ff == $past(r4[ODIV_MSB:ODIV_LSB]))
    else $error("divider select not committed");
endmodule

// file: ssrm_pkg.sv
// Package: field layout, select codes and carrier types for the synthesizer register map
package ssrm_pkg;
  localparam int WORD_W       = 32;
  localparam int SEL_W        = 3;
  localparam int NUM_REGS     = 6;
  localparam logic [2:0] SEL_FREQ = 3'h0;
  localparam logic [2:0] SEL_MOD  = 3'h1;
  localparam logic [2:0] SEL_REF  = 3'h2;
  localparam logic [2:0] SEL_CLK  = 3'h3;
  localparam logic [2:0] SEL_OUT  = 3'h4;
  localparam logic [2:0] SEL_LOCK = 3'h5;
  // Frequency word fields
  localparam int INT_MSB      = 30;
  localparam int INT_LSB      = 15;
  localparam int FRACTION_NUMERATOR_MSB     = 14;
  localparam int FRACTION_NUMERATOR_LSB     = 3;
  // Register 1 buffered fields
  localparam int PHASE_MSB    = 26;
  localparam int PHASE_LSB    = 15;
  localparam int MODUL_MSB    = 14;
  localparam int MODUL_LSB    = 3;
  // Register 2 buffered fields and divider hold enable
  localparam int DOUBLER_BIT  = 25;
  localparam int HALVE_BIT    = 24;
  localparam int RCNT_MSB     = 23;
  localparam int RCNT_LSB     = 14;
  localparam int HOLD_EN_BIT  = 13;
  localparam int PUMP_MSB     = 12;
  localparam int PUMP_LSB     = 9;
  // Register 4 output divider select
  localparam int ODIV_MSB     = 22;
  localparam int ODIV_LSB     = 20;
  // No documented reset value; all-zero chosen
  localparam logic [31:0] REG_RESET = 32'h0;
  // Synchroniser depth for crossing
  localparam int SYNC_STAGES  = 2;

  typedef struct packed {
    logic [15:0] int_word;
    logic [11:0] fraction_numerator;
  } ssrm_freq_t;

  typedef struct packed {
    logic [11:0] phase_word;
    logic [11:0] fraction_modulus;
    logic        ref_doubler;
    logic        ref_halve;
    logic [9:0]  ref_count;
    logic [3:0]  pump_current;
  } ssrm_held_t;
endpackage

// file: ssrm_latch_bank.sv
// Latch bank: six 32-bit register latches written by select code
`timescale 1ns/100ps
module ssrm_latch_bank
  import ssrm_pkg::*;
#(
  parameter int N_REGS = NUM_REGS
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              wr_en,
  input  wire logic [SEL_W-1:0]  wr_sel,
  input  wire logic [WORD_W-1:0] wr_data,
  output logic [N_REGS*WORD_W-1:0] regs_flat
);
  // Select decode and package layout assume exactly six latches
  if (N_REGS != NUM_REGS) begin : g_bad_count
    $error("ssrm_latch_bank: N_REGS must be 6");
  end

  for (genvar g = 0; g < N_REGS; g++) begin : g_reg
    always_ff @(posedge clk) begin
      if (rst) begin
        regs_flat[g*WORD_W +: WORD_W] <= REG_RESET;
      end else if (wr_en && wr_sel == SEL_W'(g)) begin
        regs_flat[g*WORD_W +: WORD_W] <= wr_data;
      end
    end
  end
endmodule

// file: ssrm_host.sv
// Host model driving the three-wire serial link
`timescale 1ns/100ps
module ssrm_host (
  output logic sclk,
  output logic sdata,
  output logic latch_strobe
);
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    latch_strobe = 1'b0;
  end

  task automatic pulse();
    #40 sclk = 1'b1;
    #80 sclk = 1'b0;
    #40;
  endtask

  // Clock stands still between frames; odd offset keeps phase unrelated
  task automatic send(input logic [31:0] w);
    #1.3;
    for (int i = 31; i >= 0; i--) begin
      sdata = w[i];
      pulse();
    end
    latch_strobe = 1'b1;
    pulse();
    pulse();
    latch_strobe = 1'b0;
    // Released line shows the inverse so a stale bit is never trusted
    sdata = ~sdata;
  endtask
endmodule

// file: tb_ssrm_top.sv
// Testbench: register map fed by a host model, checked against a reference model
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_ssrm_top;
  import ssrm_pkg::*;
  logic        clk, rst, sclk, sdata, latch_strobe, band_start_ff;
  ssrm_freq_t  freq_ff;
  ssrm_held_t  held_ff;
  logic [2:0]  out_div_ff, odiv_w;
  logic [31:0] mod_reg_ff, ref_reg_ff, clk_reg_ff, out_reg_ff, lock_reg_ff;
  logic [31:0] regs [1:5];
  logic [27:0] fw;
  logic [39:0] held_w;
  logic [70:0] n;
  logic [70:0] notes [$];
  int          bad_count, check_count;
  int          seed = 32'h692abed0;

  ssrm_host host (.sclk(sclk), .sdata(sdata), .latch_strobe(latch_strobe));
  ssrm_top dut (.clk(clk), .rst(rst), .sclk(sclk), .sdata(sdata), .latch_strobe(latch_strobe),
    .freq_ff(freq_ff), .held_ff(held_ff), .out_div_ff(out_div_ff), .mod_reg_ff(mod_reg_ff),
    .ref_reg_ff(ref_reg_ff), .clk_reg_ff(clk_reg_ff), .out_reg_ff(out_reg_ff),
    .lock_reg_ff(lock_reg_ff), .band_start_ff(band_start_ff));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Each band-start pulse must carry the oldest noted working set
  always @(negedge clk) begin
    if (!rst && band_start_ff === 1'b1) begin
      n = notes.size() ? notes.pop_front() : '1;
      `CHK("working set", n, {freq_ff, held_ff, out_div_ff})
    end
  end

  task automatic summarize();
    if (bad_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Model is updated before sending, as the pulse lands before send returns
  task automatic wr(input logic [2:0] sel, input logic hold);
    logic [31:0] w;
    w = $random(seed);
    w[31] = 1'b0;
    w[2:0] = sel;
    if (sel == 3'h0) begin
      w[30:15] = 16'(23 + w[30:15] % 65513);
      w[14:3] = regs[1][14:3] > 1 ? w[14:3] % regs[1][14:3] : 12'h0;
    end
    if (sel == 3'h1) w[30:27] = 4'h0;
    if (sel == 3'h3) w = w & 32'h80e5_ffff;
    if (sel == 3'h4) w[30:24] = 7'h0;
    if (sel == 3'h2) w[13] = hold;
    if (sel == 3'h5) w = 32'h0018_0005;
    if (sel inside {[3'h1:3'h5]}) regs[sel] = w;
    if (!regs[2][13]) odiv_w = regs[4][22:20];
    if (sel == 3'h0) begin
      fw = {w[30:15], w[14:3]};
      held_w = {regs[1][26:3], regs[2][25:14], regs[2][12:9]};
      odiv_w = regs[4][22:20];
      notes.push_back({fw, held_w, odiv_w});
    end
    host.send(w);
    repeat (12) @(negedge clk);
    `CHK("mod reg", regs[1], mod_reg_ff)
    `CHK("ref reg", regs[2], ref_reg_ff)
    `CHK("clk reg", regs[3], clk_reg_ff)
    `CHK("out reg", regs[4], out_reg_ff)
    `CHK("lock reg", regs[5], lock_reg_ff)
    `CHK("freq", fw, freq_ff)
    `CHK("held", held_w, held_ff)
    `CHK("out div", odiv_w, out_div_ff)
  endtask

  initial begin
    rst = 1'b1;
    foreach (regs[i]) regs[i] = '0;
    fw = '0;
    held_w = '0;
    odiv_w = '0;
    notes.push_back('0);
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    wr(3'h5, 1'b0);
    wr(3'h4, 1'b0);
    wr(3'h3, 1'b0);
    wr(3'h2, 1'b1);
    wr(3'h1, 1'b0);
    wr(3'h4, 1'b0);
    wr(3'h6, 1'b0);
    wr(3'h7, 1'b0);
    wr(3'h0, 1'b0);
    wr(3'h2, 1'b0);
    wr(3'h4, 1'b0);
    for (int i = 0; i < 12; i++) wr(3'($random(seed)), 1'($random(seed)));
    `CHK("pending notes", 0, notes.size())
    summarize();
  end

  initial begin
    #400000;
    bad_count++;
    summarize();
  end
endmodule
